// ===== logic/wbsq_pkg.sv
// Purpose: Shared constants and types for the white-balance and sequence block
// Assumes: APB register access, 32-bit data, byte addresses
// Notes:   Indexes are 1-based values; table address is index minus one
package wbsq_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_AREA_SEL  = 8'h00;
  localparam logic [7:0] OFF_AREA_ON   = 8'h04;
  localparam logic [7:0] OFF_ALL_ON    = 8'h08;
  localparam logic [7:0] OFF_SPEED     = 8'h0C;
  localparam logic [7:0] OFF_MODE      = 8'h10;
  localparam logic [7:0] OFF_SEQ_SEL   = 8'h14;
  localparam logic [7:0] OFF_FRAMES    = 8'h18;
  localparam logic [7:0] OFF_NEXT      = 8'h1C;
  localparam logic [7:0] OFF_WIDTH     = 8'h20;
  localparam logic [7:0] OFF_HEIGHT    = 8'h24;
  localparam logic [7:0] OFF_OFFX      = 8'h28;
  localparam logic [7:0] OFF_CMD_IDX   = 8'h2C;
  localparam logic [7:0] OFF_SEQ_RST   = 8'h30;
  localparam logic [7:0] OFF_STATUS    = 8'h34;

  // Values after reset and legal limits
  localparam logic [3:0]  AREA_SEL_RST = 4'h0;
  localparam logic [15:0] AREA_ALL     = 16'hFFFF;
  localparam logic [31:0] SPEED_MIN    = 32'h0000_0001;
  localparam logic [31:0] SPEED_MAX    = 32'h0000_0008;
  localparam logic [3:0]  SPEED_RST    = 4'h4;
  localparam logic [31:0] IDX_MIN      = 32'h0000_0001;
  localparam logic [31:0] IDX_MAX      = 32'h0000_0080;
  localparam logic [7:0]  IDX_RST      = 8'h01;
  localparam logic [31:0] FRAMES_MIN   = 32'h0000_0001;
  localparam logic [31:0] FRAMES_MAX   = 32'h0000_00FF;
  localparam logic [31:0] WIDTH_MIN    = 32'h0000_0060;
  localparam logic [31:0] WIDTH_MAX    = 32'h0000_0790;
  localparam logic [31:0] HEIGHT_MIN   = 32'h0000_0002;
  localparam logic [31:0] HEIGHT_MAX   = 32'h0000_04C0;
  localparam logic [31:0] OFFX_MIN     = 32'h0000_0000;
  localparam logic [31:0] OFFX_MAX     = 32'h0000_0730;
  localparam logic [31:0] MODE_MAX     = 32'h0000_0002;
  localparam int          TBL_DEPTH    = 128;

  typedef enum logic [1:0] {
    plain_output     = 2'h0,
    trig_step_output = 2'h1,
    cmd_step_output  = 2'h2
  } wbsq_mode_e;

  typedef struct packed {
    logic [7:0]  frames;
    logic [7:0]  next;
    logic [10:0] width;
    logic [10:0] height;
    logic [10:0] offx;
  } wbsq_entry_s;

  localparam wbsq_entry_s ENTRY_RST = '{
    frames: 8'h01,
    next:   8'h01,
    width:  11'h790,
    height: 11'h4C0,
    offx:   11'h000
  };

endpackage

// ===== logic/wbsq_seq_table.sv
// Purpose: Sequence entry table, one write port and two read ports
// Assumes: Addresses are 0-based entry numbers
// Notes:   Reads are combinational; every entry returns to defaults on reset
`timescale 1ns/10ps
module wbsq_seq_table (
  input  wire logic                  clk_sys_i,
  input  wire logic                  resetn_i,
  input  wire logic                  we_i,
  input  wire logic [6:0]            waddr_i,
  input  wire wbsq_pkg::wbsq_entry_s wdata_i,
  input  wire logic [6:0]            raddr_a_i,
  output      wbsq_pkg::wbsq_entry_s rdata_a_o,
  input  wire logic [6:0]            raddr_b_i,
  output      wbsq_pkg::wbsq_entry_s rdata_b_o
);

  wbsq_pkg::wbsq_entry_s mem [wbsq_pkg::TBL_DEPTH];

  // Flop array rather than RAM so reset can restore every default
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < wbsq_pkg::TBL_DEPTH; i++) begin
        mem[i] <= wbsq_pkg::ENTRY_RST;
      end
    end else if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  assign rdata_a_o = mem[raddr_a_i];
  assign rdata_b_o = mem[raddr_b_i];

endmodule

// ===== logic/wbsq_top.sv
// Purpose: White-balance area settings and sequence window table over APB
// Assumes: Trigger input is synchronous; one frame trigger per two cycles max
// Notes:   Out-of-range writes are refused with pslverr and change nothing
//
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/10ps
module wbsq_top (
  input  wire logic        clk_sys_i,
  input  wire logic        resetn_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output      logic [31:0] prdata_o,
  output      logic        pready_o,
  output      logic        pslverr_o,
  input  wire logic        trig_i,
  output      logic        frame_o,
  output      logic [10:0] win_width_o,
  output      logic [10:0] win_height_o,
  output      logic [10:0] win_offx_o,
  output      logic [7:0]  cur_index_o,
  output      logic [1:0]  mode_o,
  output      logic [15:0] wb_area_use_o,
  output      logic [3:0]  wb_loop_speed_o
);

  typedef enum logic {SEQ_WAIT, SEQ_EMIT} wbsq_seq_e;

  function automatic logic in_rng(input logic [31:0] v,
                                  input logic [31:0] lo,
                                  input logic [31:0] hi);
    in_rng = (v >= lo) && (v <= hi);
  endfunction

  logic [3:0]            wb_area_select;
  logic [15:0]           wb_area_on;
  logic                  wb_all_areas_on;
  logic [3:0]            wb_loop_speed;
  wbsq_pkg::wbsq_mode_e  mode;
  logic [7:0]            seq_sel;
  logic [7:0]            cmd_idx;
  logic [7:0]            cur_idx;
  logic [7:0]            frame_cnt;
  wbsq_seq_e             state;
  wbsq_seq_e             next_state;
  wbsq_pkg::wbsq_entry_s sel_entry;
  wbsq_pkg::wbsq_entry_s cur_entry;
  wbsq_pkg::wbsq_entry_s tbl_wdata;

  // Bus decode
  wire        setup_ph = psel_i & ~penable_i;
  wire        access   = psel_i & penable_i;
  wire [31:0] wd       = pwdata_i;
  wire hit_sel    = paddr_i == wbsq_pkg::OFF_AREA_SEL;
  wire hit_on     = paddr_i == wbsq_pkg::OFF_AREA_ON;
  wire hit_all    = paddr_i == wbsq_pkg::OFF_ALL_ON;
  wire hit_speed  = paddr_i == wbsq_pkg::OFF_SPEED;
  wire hit_mode   = paddr_i == wbsq_pkg::OFF_MODE;
  wire hit_seq    = paddr_i == wbsq_pkg::OFF_SEQ_SEL;
  wire hit_frames = paddr_i == wbsq_pkg::OFF_FRAMES;
  wire hit_next   = paddr_i == wbsq_pkg::OFF_NEXT;
  wire hit_width  = paddr_i == wbsq_pkg::OFF_WIDTH;
  wire hit_height = paddr_i == wbsq_pkg::OFF_HEIGHT;
  wire hit_offx   = paddr_i == wbsq_pkg::OFF_OFFX;
  wire hit_cmd    = paddr_i == wbsq_pkg::OFF_CMD_IDX;
  wire hit_rst    = paddr_i == wbsq_pkg::OFF_SEQ_RST;
  wire hit_stat   = paddr_i == wbsq_pkg::OFF_STATUS;
  wire hit_entry  = hit_frames | hit_next | hit_width | hit_height | hit_offx;
  wire mapped     = hit_sel | hit_on | hit_all | hit_speed | hit_mode |
                    hit_seq | hit_entry | hit_cmd | hit_rst | hit_stat;

  // Range check of the write data per target
  wire ok_idx = in_rng(wd, wbsq_pkg::IDX_MIN, wbsq_pkg::IDX_MAX);
  wire wr_legal =
    hit_sel    ? (wd[31:4] == 28'h000_0000) :
    hit_on     ? (wd[31:1] == 31'h0000_0000) :
    hit_all    ? (wd[31:1] == 31'h0000_0000) :
    hit_speed  ? in_rng(wd, wbsq_pkg::SPEED_MIN,
                        wbsq_pkg::SPEED_MAX) :
    hit_mode   ? (wd <= wbsq_pkg::MODE_MAX) :
    hit_seq    ? ok_idx :
    hit_frames ? in_rng(wd, wbsq_pkg::FRAMES_MIN,
                        wbsq_pkg::FRAMES_MAX) :
    hit_next   ? ok_idx :
    hit_width  ? in_rng(wd, wbsq_pkg::WIDTH_MIN,
                        wbsq_pkg::WIDTH_MAX) :
    hit_height ? in_rng(wd, wbsq_pkg::HEIGHT_MIN,
                        wbsq_pkg::HEIGHT_MAX) :
    hit_offx   ? in_rng(wd, wbsq_pkg::OFFX_MIN,
                        wbsq_pkg::OFFX_MAX) :
    hit_cmd    ? ok_idx :
    hit_rst;
  wire wr_err = access & pwrite_i & ~(mapped & wr_legal);
  wire wr_ok  = access & pwrite_i & mapped & wr_legal;

  assign pready_o  = 1'b1;
  assign pslverr_o = access & (~mapped | wr_err);

  // Entry table, port a for register access, port b for the output path
  assign tbl_wdata = '{
    frames: hit_frames ? wd[7:0]  : sel_entry.frames,
    next:   hit_next   ? wd[7:0]  : sel_entry.next,
    width:  hit_width  ? wd[10:0] : sel_entry.width,
    height: hit_height ? wd[10:0] : sel_entry.height,
    offx:   hit_offx   ? wd[10:0] : sel_entry.offx
  };

  wbsq_seq_table u_table (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .we_i      (wr_ok & hit_entry),
    .waddr_i   (7'(seq_sel - 8'h01)),
    .wdata_i   (tbl_wdata),
    .raddr_a_i (7'(seq_sel - 8'h01)),
    .rdata_a_o (sel_entry),
    .raddr_b_i (7'(cur_idx - 8'h01)),
    .rdata_b_o (cur_entry)
  );

  // Read data, captured in the setup cycle so it comes from a flop
  wire [31:0] rd_val =
    hit_sel    ? {28'h000_0000, wb_area_select} :
    hit_on     ? {31'h0000_0000, wb_area_on[wb_area_select]} :
    hit_all    ? {31'h0000_0000, wb_all_areas_on} :
    hit_speed  ? {28'h000_0000, wb_loop_speed} :
    hit_mode   ? {30'h0000_0000, mode} :
    hit_seq    ? {24'h00_0000, seq_sel} :
    hit_frames ? {24'h00_0000, sel_entry.frames} :
    hit_next   ? {24'h00_0000, sel_entry.next} :
    hit_width  ? {21'h00_0000, sel_entry.width} :
    hit_height ? {21'h00_0000, sel_entry.height} :
    hit_offx   ? {21'h00_0000, sel_entry.offx} :
    hit_cmd    ? {24'h00_0000, cmd_idx} :
    hit_stat   ? {16'h0000, frame_cnt, cur_idx} :
    32'h0000_0000;

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (setup_ph & ~pwrite_i) begin
      prdata_o <= rd_val;
    end
  end

  // White-balance settings
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      wb_area_select  <= wbsq_pkg::AREA_SEL_RST;
      wb_area_on      <= 16'h0000;
      wb_all_areas_on <= 1'b1;
      wb_loop_speed   <= wbsq_pkg::SPEED_RST;
    end else if (wr_ok) begin
      if (hit_sel) wb_area_select <= wd[3:0];
      if (hit_on) wb_area_on[wb_area_select] <= wd[0];
      if (hit_all) wb_all_areas_on <= wd[0];
      if (hit_speed) wb_loop_speed <= wd[3:0];
    end
  end

  // Area mask handed to the balance loop
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      wb_area_use_o <= wbsq_pkg::AREA_ALL;
    end else begin
      wb_area_use_o <= wb_all_areas_on ? wbsq_pkg::AREA_ALL
                                       : wb_area_on;
    end
  end

  assign wb_loop_speed_o = wb_loop_speed;
  assign mode_o          = mode;

  // Mode, selectors and sequence position
  wire seq_reset = wr_ok & hit_rst;
  wire cmd_write = wr_ok & hit_cmd;
  wire taken     = (state == SEQ_WAIT) & trig_i;
  wire trig_mode = mode == wbsq_pkg::trig_step_output;
  wire last_rep  = (frame_cnt + 8'h01) >= cur_entry.frames;

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      mode    <= wbsq_pkg::plain_output;
      seq_sel <= wbsq_pkg::IDX_RST;
    end else if (wr_ok) begin
      if (hit_mode) mode <= wbsq_pkg::wbsq_mode_e'(wd[1:0]);
      if (hit_seq) seq_sel <= wd[7:0];
    end
  end

  // A reset command wins over a trigger or an index write in the same cycle
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      cur_idx   <= wbsq_pkg::IDX_RST;
      cmd_idx   <= wbsq_pkg::IDX_RST;
      frame_cnt <= 8'h00;
    end else if (seq_reset) begin
      cur_idx   <= wbsq_pkg::IDX_RST;
      cmd_idx   <= wbsq_pkg::IDX_RST;
      frame_cnt <= 8'h00;
    end else if (cmd_write) begin
      cmd_idx <= wd[7:0];
      if (mode == wbsq_pkg::cmd_step_output) cur_idx <= wd[7:0];
    end else if (taken && trig_mode) begin
      if (last_rep) begin
        cur_idx   <= cur_entry.next;
        frame_cnt <= 8'h00;
      end else begin
        frame_cnt <= frame_cnt + 8'h01;
      end
    end
  end

  // Frame emission; a trigger during the emit cycle is dropped
  always_comb begin
    case (state)
      SEQ_WAIT: next_state = trig_i ? SEQ_EMIT : SEQ_WAIT;
      SEQ_EMIT: next_state = SEQ_WAIT;
      default:  next_state = SEQ_WAIT;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      state <= SEQ_WAIT;
    end else begin
      state <= next_state;
    end
  end

  assign frame_o     = state == SEQ_EMIT;
  assign cur_index_o = cur_idx;

  // Plain mode sends the full default window
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      win_width_o  <= wbsq_pkg::ENTRY_RST.width;
      win_height_o <= wbsq_pkg::ENTRY_RST.height;
      win_offx_o   <= wbsq_pkg::ENTRY_RST.offx;
    end else if (taken) begin
      if (mode == wbsq_pkg::plain_output) begin
        win_width_o  <= wbsq_pkg::ENTRY_RST.width;
        win_height_o <= wbsq_pkg::ENTRY_RST.height;
        win_offx_o   <= wbsq_pkg::ENTRY_RST.offx;
      end else begin
        win_width_o  <= cur_entry.width;
        win_height_o <= cur_entry.height;
        win_offx_o   <= cur_entry.offx;
      end
    end
  end

  chk_area_rst_low: assert property (
    @(posedge clk_sys_i) $rose(resetn_i) |->
      wb_area_select == wbsq_pkg::AREA_SEL_RST && wb_area_on == 16'h0000)
    else $error("area selector or enables not at reset value");

  chk_area_on_write: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
      wr_ok && hit_on |=>
      wb_area_on[$past(wb_area_select)] == $past(pwdata_i[0]))
    else $error("area enable not written at selected area");

  chk_all_areas_mask: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
      wb_all_areas_on |=> wb_area_use_o == wbsq_pkg::AREA_ALL)
    else $error("enable-all did not select every area");

  chk_single_mask: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
      !wb_all_areas_on |=> wb_area_use_o == $past(wb_area_on))
    else $error("area mask does not follow per-area enables");

  chk_speed_legal: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
      wb_loop_speed >= 4'h1 && wb_loop_speed <= 4'h8)
    else $error("loop speed out of range");

  chk_mode_value: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
      access && pwrite_i && hit_mode && wd > wbsq_pkg::MODE_MAX |->
      pslverr_o ##1 $stable(mode))
    else $error("illegal mode write not refused");

  chk_seq_sel_range: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
      seq_sel >= 8'h01 && seq_sel <= 8'h80)
    else $error("entry selector out of range");

  chk_frames_refuse: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
      access && pwrite_i && hit_frames && wd == 32'h0000_0000 |->
      pslverr_o ##1 sel_entry.frames == $past(sel_entry.frames))
    else $error("zero frame count accepted");

  chk_seq_reset_one: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
      seq_reset |=> cur_idx == 8'h01 && frame_cnt == 8'h00)
    else $error("sequence reset did not return to entry 1");

  chk_trig_link: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
      taken && trig_mode && last_rep && !seq_reset && !cmd_write |=>
      cur_idx == $past(cur_entry.next) ##1 frame_cnt == 8'h00 || taken)
    else $error("link not taken after last frame");

  chk_frame_pulse: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
      taken |=> frame_o ##1 !frame_o)
    else $error("frame pulse not one cycle after trigger");

  chk_win_entry: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
      taken && mode != wbsq_pkg::plain_output |=>
      win_width_o == $past(cur_entry.width) &&
      win_height_o == $past(cur_entry.height) &&
      win_offx_o == $past(cur_entry.offx))
    else $error("window does not match current entry");

  chk_plain_window: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
      taken && mode == wbsq_pkg::plain_output |=>
      win_width_o == wbsq_pkg::ENTRY_RST.width &&
      win_height_o == wbsq_pkg::ENTRY_RST.height &&
      win_offx_o == wbsq_pkg::ENTRY_RST.offx)
    else $error("plain mode window not the full frame");

  chk_refused_still: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
      wr_err |=> $stable(wb_loop_speed) && $stable(mode) &&
      $stable(seq_sel) && $stable(cmd_idx) && $stable(wb_area_select))
    else $error("refused write changed a setting");

  chk_cur_idx_range: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
      cur_idx >= 8'h01 && cur_idx <= 8'h80)
    else $error("sequence position out of range");

  chk_entry_legal: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
      sel_entry.width >= 11'h060 && sel_entry.width <= 11'h790 &&
      sel_entry.height >= 11'h002 && sel_entry.height <= 11'h4C0 &&
      sel_entry.offx <= 11'h730 && sel_entry.frames != 8'h00)
    else $error("stored entry field out of range");

endmodule

// ===== dv/tb.sv
// Purpose: Self-checking bench for the white-balance and sequence block
// Assumes: APB slave may add wait states; trigger spacing of two cycles
// Notes:   Registers are checked against values that follow from reset
`timescale 1ns/10ps
module tb;
  logic        clk_sys_i;
  logic        resetn_i;
  logic        psel_i;
  logic        penable_i;
  logic        pwrite_i;
  logic [7:0]  paddr_i;
  logic [31:0] pwdata_i;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic        trig_i;
  logic        frame_o;
  logic [10:0] win_width_o;
  logic [10:0] win_height_o;
  logic [10:0] win_offx_o;
  logic [7:0]  cur_index_o;
  logic [1:0]  mode_o;
  logic [15:0] wb_area_use_o;
  logic [3:0]  wb_loop_speed_o;
  int          fails;
  int          n_tests;
  // Out-of-range writes: address and value pairs
  logic [7:0]  bad_a [17] = '{8'h00, 8'h0C, 8'h0C, 8'h10, 8'h14, 8'h14,
    8'h18, 8'h18, 8'h1C, 8'h1C, 8'h20, 8'h20, 8'h24, 8'h24, 8'h28,
    8'h2C, 8'h2C};
  logic [31:0] bad_d [17] = '{32'h0000_0010, 32'h0000_0000,
    32'h0000_0009, 32'h0000_0003, 32'h0000_0000, 32'h0000_0081,
    32'h0000_0000, 32'h0000_0100, 32'h0000_0000, 32'h0000_0081,
    32'h0000_005F, 32'h0000_0791, 32'h0000_0001, 32'h0000_04C1,
    32'h0000_0731, 32'h0000_0000, 32'h0000_0081};

  wbsq_top dut (
    .clk_sys_i       (clk_sys_i),
    .resetn_i        (resetn_i),
    .psel_i          (psel_i),
    .penable_i       (penable_i),
    .pwrite_i        (pwrite_i),
    .paddr_i         (paddr_i),
    .pwdata_i        (pwdata_i),
    .prdata_o        (prdata_o),
    .pready_o        (pready_o),
    .pslverr_o       (pslverr_o),
    .trig_i          (trig_i),
    .frame_o         (frame_o),
    .win_width_o     (win_width_o),
    .win_height_o    (win_height_o),
    .win_offx_o      (win_offx_o),
    .cur_index_o     (cur_index_o),
    .mode_o          (mode_o),
    .wb_area_use_o   (wb_area_use_o),
    .wb_loop_speed_o (wb_loop_speed_o)
  );

  always #5 clk_sys_i = ~clk_sys_i;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Requests held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    @(posedge clk_sys_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= wr;
    paddr_i   <= a;
    pwdata_i  <= d;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    @(posedge clk_sys_i);
    while (pready_o !== 1'b1) begin
      @(posedge clk_sys_i);
    end
    rd = prdata_o;
    err = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic wr_chk(input logic [7:0] a, input logic [31:0] d,
                        input logic e);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, a, d, rd, err);
    chk({31'h0, err}, {31'h0, e});
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h0000_0000, rd, err);
    chk(rd, exp);
    chk({31'h0, err}, 32'h0000_0000);
  endtask

  function automatic logic [31:0] rst_val(input logic [7:0] a);
    case (a)
      8'h08, 8'h14, 8'h18, 8'h1C, 8'h2C: rst_val = 32'h0000_0001;
      8'h0C:   rst_val = 32'h0000_0004;
      8'h20:   rst_val = 32'h0000_0790;
      8'h24:   rst_val = 32'h0000_04C0;
      default: rst_val = 32'h0000_0000;
    endcase
  endfunction

  // One trigger, then the emitted window and position
  task automatic trig_chk(input logic [10:0] w, input logic [10:0] h,
                          input logic [10:0] x, input logic [7:0] idx);
    @(posedge clk_sys_i);
    trig_i <= 1'b1;
    @(posedge clk_sys_i);
    trig_i <= 1'b0;
    #1;
    chk({31'h0, frame_o}, 32'h0000_0001);
    chk({21'h0, win_width_o}, {21'h0, w});
    chk({21'h0, win_height_o}, {21'h0, h});
    chk({21'h0, win_offx_o}, {21'h0, x});
    chk({24'h0, cur_index_o}, {24'h0, idx});
  endtask

  task automatic t_reset;
    for (int i = 0; i < 6; i++) begin
      rd_chk(8'(i * 4), rst_val(8'(i * 4)));
    end
    for (int i = 6; i < 11; i++) begin
      rd_chk(8'(i * 4), rst_val(8'(i * 4)));
    end
    chk({16'h0, wb_area_use_o}, 32'h0000_FFFF);
    chk({28'h0, wb_loop_speed_o}, 32'h0000_0004);
    chk({30'h0, mode_o}, 32'h0000_0000);
    trig_chk(11'h790, 11'h4C0, 11'h000, 8'h01);
  endtask

  task automatic t_refuse;
    for (int i = 0; i < 17; i++) begin
      wr_chk(bad_a[i], bad_d[i], 1'b1);
      rd_chk(bad_a[i], rst_val(bad_a[i]));
    end
    wr_chk(8'h34, 32'h0000_0000, 1'b1);
    wr_chk(8'h38, 32'h0000_0001, 1'b1);
    wr_chk(8'h0C, 32'h0000_0008, 1'b0);
    @(posedge clk_sys_i);
    chk({28'h0, wb_loop_speed_o}, 32'h0000_0008);
    wr_chk(8'h0C, 32'h0000_0001, 1'b0);
    @(posedge clk_sys_i);
    chk({28'h0, wb_loop_speed_o}, 32'h0000_0001);
  endtask

  task automatic t_areas;
    wr_chk(8'h00, 32'h0000_000F, 1'b0);
    wr_chk(8'h04, 32'h0000_0001, 1'b0);
    wr_chk(8'h00, 32'h0000_0000, 1'b0);
    wr_chk(8'h04, 32'h0000_0001, 1'b0);
    wr_chk(8'h00, 32'h0000_0001, 1'b0);
    rd_chk(8'h04, 32'h0000_0000);
    @(posedge clk_sys_i);
    chk({16'h0, wb_area_use_o}, 32'h0000_FFFF);
    wr_chk(8'h08, 32'h0000_0000, 1'b0);
    repeat (2) @(posedge clk_sys_i);
    chk({16'h0, wb_area_use_o}, 32'h0000_8001);
    wr_chk(8'h08, 32'h0000_0001, 1'b0);
    repeat (2) @(posedge clk_sys_i);
    chk({16'h0, wb_area_use_o}, 32'h0000_FFFF);
  endtask

  task automatic t_trig_seq;
    wr_chk(8'h14, 32'h0000_0080, 1'b0);
    wr_chk(8'h18, 32'h0000_00FF, 1'b0);
    wr_chk(8'h1C, 32'h0000_0080, 1'b0);
    rd_chk(8'h18, 32'h0000_00FF);
    rd_chk(8'h1C, 32'h0000_0080);
    wr_chk(8'h14, 32'h0000_0001, 1'b0);
    wr_chk(8'h18, 32'h0000_0002, 1'b0);
    wr_chk(8'h1C, 32'h0000_0003, 1'b0);
    wr_chk(8'h20, 32'h0000_0060, 1'b0);
    wr_chk(8'h24, 32'h0000_0002, 1'b0);
    wr_chk(8'h28, 32'h0000_0730, 1'b0);
    wr_chk(8'h14, 32'h0000_0003, 1'b0);
    wr_chk(8'h20, 32'h0000_01F4, 1'b0);
    trig_chk(11'h790, 11'h4C0, 11'h000, 8'h01);
    wr_chk(8'h10, 32'h0000_0001, 1'b0);
    trig_chk(11'h060, 11'h002, 11'h730, 8'h01);
    trig_chk(11'h060, 11'h002, 11'h730, 8'h03);
    trig_chk(11'h1F4, 11'h4C0, 11'h000, 8'h01);
    trig_chk(11'h060, 11'h002, 11'h730, 8'h01);
    trig_chk(11'h060, 11'h002, 11'h730, 8'h03);
    wr_chk(8'h30, 32'h0000_0000, 1'b0);
    @(posedge clk_sys_i);
    chk({24'h0, cur_index_o}, 32'h0000_0001);
    trig_chk(11'h060, 11'h002, 11'h730, 8'h01);
    rd_chk(8'h34, 32'h0000_0101);
  endtask

  task automatic t_cmd_seq;
    wr_chk(8'h10, 32'h0000_0002, 1'b0);
    wr_chk(8'h2C, 32'h0000_0005, 1'b0);
    @(posedge clk_sys_i);
    chk({24'h0, cur_index_o}, 32'h0000_0005);
    chk({30'h0, mode_o}, 32'h0000_0002);
    wr_chk(8'h30, 32'h0000_0000, 1'b0);
    @(posedge clk_sys_i);
    chk({24'h0, cur_index_o}, 32'h0000_0001);
    rd_chk(8'h2C, 32'h0000_0001);
  endtask

  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Whole run needs under 300 cycles; a hundred times that is a hang
  initial begin
    repeat (30000) @(posedge clk_sys_i);
    fails++;
    finish_test();
  end

  initial begin
    clk_sys_i = 1'b0;
    resetn_i  = 1'b0;
    psel_i    = 1'b0;
    penable_i = 1'b0;
    pwrite_i  = 1'b0;
    paddr_i   = 8'h00;
    pwdata_i  = 32'h0000_0000;
    trig_i    = 1'b0;
    fails     = 0;
    n_tests   = 0;
    repeat (10) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    t_reset();
    t_refuse();
    t_areas();
    t_trig_seq();
    t_cmd_seq();
    finish_test();
  end
endmodule
